// >>> hdl/gdmf_ctrl.sv
// gdmf_ctrl: mode, supply gating, gate forcing, dead gap and fault latch of a three-phase gate driver
// assumes: all inputs synchronous to clk_sys, apb master on the same clock, alarm pin pulled up outside
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`include "gdmf_map.svh"

module gdmf_ctrl
#(
   parameter int NF                = 4,
   parameter int OE_LOW_CYC        = (`GDMF_OE_LOW_NS + `GDMF_CLK_NS - 1) / `GDMF_CLK_NS,
   parameter int BIAS_TMO_CYC      = (`GDMF_BIAS_TMO_NS + `GDMF_CLK_NS - 1) / `GDMF_CLK_NS,
   parameter int RESUME_LOW_MIN_NS = `GDMF_RESUME_LOW_NS
)
(
   input  wire logic                  clk_sys,
   input  wire logic                  rst_b,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output      logic [31:0]           prdata,
   output      logic                  pready,
   output      logic                  pslverr,
   input  wire logic                  out_enable,
   input  wire logic                  wake_in,
   input  wire gdmf_pkg::gdmf_gate_s  phase_cmd,
   input  wire logic [NF-1:0]         fault_cond,
   input  wire logic                  ldo_ready,
   input  wire logic                  gate_bias_ready,
   input  wire logic                  pump_request,
   output      gdmf_pkg::gdmf_gate_s  gate_out,
   output      gdmf_pkg::gdmf_supply_s supply,
   output      logic                  alarm_o,
   output      logic                  alarm_oe,
   output      logic                  irq
);

   localparam int RESUME_CYC = (RESUME_LOW_MIN_NS + `GDMF_CLK_NS - 1) / `GDMF_CLK_NS;
   localparam int GATE_OFF_CYC = `GDMF_GATE_OFF_NS / `GDMF_CLK_NS;
   localparam int OW = $clog2(OE_LOW_CYC + 1);
   localparam int BW = $clog2(BIAS_TMO_CYC + 1);
   localparam int WW = $clog2(RESUME_CYC + 2);
   localparam logic [OW-1:0] OE_LOW_MAX = OW'(OE_LOW_CYC);
   localparam logic [BW-1:0] BIAS_MAX   = BW'(BIAS_TMO_CYC);
   localparam logic [WW-1:0] WAKE_MAX   = WW'(RESUME_CYC);

   gdmf_pkg::gdmf_mode_e   state;
   gdmf_pkg::gdmf_mode_e   next_state;
   gdmf_pkg::gdmf_supply_s next_supply;
   logic [1:0]             config_reg_zero;
   logic [`GDMF_GAP_W-1:0] dead_gap_config;
   logic [`GDMF_EV_W-1:0]  int_stat;
   logic [`GDMF_EV_W-1:0]  int_mask;
   logic [`GDMF_EV_W-1:0]  next_int_stat;
   logic [`GDMF_EV_W-1:0]  events;
   logic [NF-1:0]          fault_latch;
   logic [NF-1:0]          next_fault_latch;
   logic [OW-1:0]          oe_low_cnt;
   logic [BW-1:0]          bias_cnt;
   logic [WW-1:0]          wake_low_cnt;
   logic                   oe_q;
   logic                   wake_q;
   logic [2:0]             next_hi;
   logic [2:0]             next_lo;
   logic [`GDMF_GAP_W-1:0] gap_cnt [3];

   wire amp_standby_off = config_reg_zero[`GDMF_CFG_AMP_OFF_BIT];
   wire deep_idle_sel   = config_reg_zero[`GDMF_CFG_DEEP_IDLE_BIT];
   wire oe_rise         = out_enable & ~oe_q;
   wire low_ok          = (oe_low_cnt == OE_LOW_MAX);
   wire wake_ok         = wake_in & ~wake_q & (wake_low_cnt == WAKE_MAX);
   wire bias_done       = gate_bias_ready | (bias_cnt == BIAS_MAX);
   wire drive_ok        = out_enable & (state == gdmf_pkg::GDMF_ACTIVE);
   wire startup         = (state == gdmf_pkg::GDMF_LDO_START);

   // apb decode
   wire acc_first = psel & penable & ~pready;
   wire acc_done  = psel & penable & pready;
   wire hit_cfg   = (paddr == `GDMF_CONFIG_REG_ZERO_OFS);
   wire hit_gap   = (paddr == `GDMF_DEAD_GAP_CONFIG_OFS);
   wire hit_stat  = (paddr == `GDMF_STATUS_OFS);
   wire hit_int   = (paddr == `GDMF_INT_STAT_OFS);
   wire hit_mask  = (paddr == `GDMF_INT_MASK_OFS);
   wire hit_any   = hit_cfg | hit_gap | hit_stat | hit_int | hit_mask;
   wire wr_done   = acc_done & pwrite;

   wire [31:0] status_word = (32'(3'(state)) << `GDMF_ST_MODE_LSB)
                           | (32'(fault_latch) << `GDMF_ST_LATCH_LSB)
                           | (32'(fault_cond) << `GDMF_ST_COND_LSB);
   wire [31:0] rd_mux = hit_cfg  ? 32'(config_reg_zero) :
                        hit_gap  ? 32'(dead_gap_config) :
                        hit_stat ? status_word :
                        hit_int  ? 32'(int_stat) :
                        hit_mask ? 32'(int_mask) : 32'h0000_0000;

   // fault latch: present condition sets and wins over the enable-rise clear
   assign next_fault_latch = (fault_latch & ~({NF{oe_rise}} & ~fault_cond)) | fault_cond;

   // interrupt events and write-one-to-clear, set wins
   assign events[`GDMF_EV_FAULT]     = |(fault_cond & ~fault_latch);
   assign events[`GDMF_EV_LOW_POWER] = (next_state != state) &&
                                       (next_state == gdmf_pkg::GDMF_STANDBY || next_state == gdmf_pkg::GDMF_SLEEP);
   assign events[`GDMF_EV_ACTIVE]    = (next_state != state) && (next_state == gdmf_pkg::GDMF_ACTIVE);
   assign events[`GDMF_EV_WAKE]      = (state == gdmf_pkg::GDMF_SLEEP) & wake_ok;
   assign next_int_stat = (int_stat & ~((wr_done & hit_int) ? pwdata[`GDMF_EV_W-1:0] : `GDMF_EV_RESET)) | events;

   // mode sequencing
   always_comb
   begin
      next_state = state;
      case (state)
         gdmf_pkg::GDMF_LDO_START:
            if (ldo_ready)
               next_state = gdmf_pkg::GDMF_BIAS_START;
         gdmf_pkg::GDMF_BIAS_START, gdmf_pkg::GDMF_ACTIVE:
            if (low_ok)
               next_state = deep_idle_sel ? gdmf_pkg::GDMF_SLEEP : gdmf_pkg::GDMF_STANDBY;
            else if (state == gdmf_pkg::GDMF_BIAS_START && bias_done)
               next_state = gdmf_pkg::GDMF_ACTIVE;
         gdmf_pkg::GDMF_STANDBY:
            if (out_enable)
               next_state = gdmf_pkg::GDMF_BIAS_START;
         gdmf_pkg::GDMF_SLEEP:
            if (wake_ok)
               next_state = gdmf_pkg::GDMF_LDO_START;
         default:
            next_state = gdmf_pkg::GDMF_LDO_START;
      endcase
   end

   // supply gating
   always_comb
   begin
      next_supply = '0;
      next_supply.logic_ldo_en = (state != gdmf_pkg::GDMF_SLEEP);
      next_supply.gate_bias_en = (state == gdmf_pkg::GDMF_BIAS_START) ||
                                 (state == gdmf_pkg::GDMF_ACTIVE);
      next_supply.pump_en = next_supply.gate_bias_en & pump_request;
      next_supply.bias_from_pump = next_supply.pump_en;
      next_supply.amp_en = (state != gdmf_pkg::GDMF_SLEEP) && !(!out_enable && amp_standby_off);
   end

   // per-phase drive with optional dead gap and shoot-through guard
   for (genvar p = 0; p < 3; p++)
   begin : g_phase
      wire want_hi  = phase_cmd.hi[p] & ~phase_cmd.lo[p] & drive_ok;
      wire want_lo  = phase_cmd.lo[p] & ~phase_cmd.hi[p] & drive_ok;
      wire gap_busy = (gap_cnt[p] != '0);
      assign next_hi[p] = want_hi & (gate_out.hi[p] | (~gate_out.lo[p] & ~gap_busy));
      assign next_lo[p] = want_lo & (gate_out.lo[p] | (~gate_out.hi[p] & ~gap_busy));
      wire turn_off = (gate_out.hi[p] & ~next_hi[p]) | (gate_out.lo[p] & ~next_lo[p]);

      always_ff @(posedge clk_sys or negedge rst_b)
      begin
         if (!rst_b)
            gap_cnt[p] <= `GDMF_GAP_RESET;
         else if (turn_off)
            gap_cnt[p] <= dead_gap_config;
         else if (gap_busy)
            gap_cnt[p] <= gap_cnt[p] - `GDMF_GAP_W'(1);
      end
   end

   // qualification counters
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         oe_low_cnt   <= '0;
         bias_cnt     <= '0;
         wake_low_cnt <= '0;
         oe_q         <= 1'b0;
         wake_q       <= 1'b0;
      end
      else
      begin
         oe_low_cnt   <= out_enable ? '0 : (low_ok ? oe_low_cnt : oe_low_cnt + OW'(1));
         bias_cnt     <= (state != gdmf_pkg::GDMF_BIAS_START) ? '0 :
                         (bias_cnt == BIAS_MAX ? bias_cnt : bias_cnt + BW'(1));
         wake_low_cnt <= wake_in ? ((wake_q) ? '0 : wake_low_cnt) :
                         (wake_low_cnt == WAKE_MAX ? wake_low_cnt : wake_low_cnt + WW'(1));
         oe_q         <= out_enable;
         wake_q       <= wake_in;
      end
   end

   // state, outputs and faults
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state       <= gdmf_pkg::GDMF_LDO_START;
         gate_out    <= '0;
         supply      <= '0;
         fault_latch <= '0;
         alarm_o     <= 1'b0;
         alarm_oe    <= 1'b1;
      end
      else
      begin
         state       <= next_state;
         gate_out    <= {next_hi, next_lo};
         supply      <= next_supply;
         fault_latch <= next_fault_latch;
         alarm_o     <= 1'b0;
         alarm_oe    <= (|next_fault_latch) | (next_state == gdmf_pkg::GDMF_LDO_START);
      end
   end

   // apb slave: one wait state, registered answer
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pready          <= 1'b0;
         pslverr         <= 1'b0;
         prdata          <= 32'h0000_0000;
         config_reg_zero <= `GDMF_CFG_RESET;
         dead_gap_config <= `GDMF_GAP_RESET;
         int_stat        <= `GDMF_EV_RESET;
         int_mask        <= `GDMF_EV_RESET;
         irq             <= 1'b0;
      end
      else
      begin
         pready   <= acc_first;
         pslverr  <= acc_first & ~hit_any;
         prdata   <= (acc_first & ~pwrite) ? rd_mux : 32'h0000_0000;
         int_stat <= next_int_stat;
         irq      <= |(next_int_stat & int_mask);
         if (wr_done & hit_cfg)
            config_reg_zero <= pwdata[1:0];
         if (wr_done & hit_gap)
            dead_gap_config <= pwdata[`GDMF_GAP_W-1:0];
         if (wr_done & hit_mask)
            int_mask <= pwdata[`GDMF_EV_W-1:0];
      end
   end

   // checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);

   property p_gate_off;
      $fell(out_enable) |-> ##[1:GATE_OFF_CYC] (gate_out == '0);
   endproperty
   a_gate_off: assert property (p_gate_off) else $error("gates not low after enable fell");

   property p_active_on;
      (state == gdmf_pkg::GDMF_ACTIVE) && out_enable |=> supply.gate_bias_en && supply.logic_ldo_en && supply.amp_en;
   endproperty
   a_active_on: assert property (p_active_on) else $error("active mode lost a function");

   property p_no_drive_low;
      !out_enable |=> (gate_out == '0);
   endproperty
   a_no_drive_low: assert property (p_no_drive_low) else $error("gates driven with enable low");

   property p_standby_off;
      (state == gdmf_pkg::GDMF_STANDBY) |=> !supply.gate_bias_en && !supply.pump_en;
   endproperty
   a_standby_off: assert property (p_standby_off) else $error("bias or pump on in standby");

   property p_amp_off;
      !out_enable && amp_standby_off |=> !supply.amp_en;
   endproperty
   a_amp_off: assert property (p_amp_off) else $error("amplifiers on with enable low");

   property p_short_low;
      (state == gdmf_pkg::GDMF_ACTIVE) && !out_enable && !low_ok |=> (state == gdmf_pkg::GDMF_ACTIVE);
   endproperty
   a_short_low: assert property (p_short_low) else $error("left active before low qualified");

   property p_sleep_sel;
      (state == gdmf_pkg::GDMF_ACTIVE) && !out_enable && low_ok && deep_idle_sel |=> (state == gdmf_pkg::GDMF_SLEEP);
   endproperty
   a_sleep_sel: assert property (p_sleep_sel) else $error("sleep not entered");

   property p_standby_sel;
      (state == gdmf_pkg::GDMF_ACTIVE) && !out_enable && low_ok && !deep_idle_sel
         |=> (state == gdmf_pkg::GDMF_STANDBY);
   endproperty
   a_standby_sel: assert property (p_standby_sel) else $error("standby not entered");

   property p_fault_clear;
      oe_rise && (fault_cond == '0) ##1 (fault_cond == '0) && !startup |=> !alarm_oe;
   endproperty
   a_fault_clear: assert property (p_fault_clear) else $error("alarm held after clearing rise");

   property p_alarm_on;
      (|fault_cond) |=> alarm_oe && !alarm_o;
   endproperty
   a_alarm_on: assert property (p_alarm_on) else $error("alarm not pulled low on fault");

   property p_alarm_hold;
      (|fault_latch) && !oe_rise |=> alarm_oe;
   endproperty
   a_alarm_hold: assert property (p_alarm_hold) else $error("alarm released without enable rise");

   property p_startup_alarm;
      startup |-> alarm_oe;
   endproperty
   a_startup_alarm: assert property (p_startup_alarm) else $error("alarm released during start-up");

   property p_wake_qual;
      (state == gdmf_pkg::GDMF_SLEEP) && !wake_ok |=> (state == gdmf_pkg::GDMF_SLEEP);
   endproperty
   a_wake_qual: assert property (p_wake_qual) else $error("sleep left without qualified wake");

   property p_ldo;
      (state == gdmf_pkg::GDMF_SLEEP) |=> !supply.logic_ldo_en;
   endproperty
   a_ldo: assert property (p_ldo) else $error("logic regulator on in sleep");

   property p_no_shoot;
      (gate_out.hi & gate_out.lo) == 3'h0;
   endproperty
   a_no_shoot: assert property (p_no_shoot) else $error("upper and lower gate on together");

   property p_bias_src;
      supply.bias_from_pump == supply.pump_en;
   endproperty
   a_bias_src: assert property (p_bias_src) else $error("bias source disagrees with pump");

   property p_bias_tmo;
      (state == gdmf_pkg::GDMF_BIAS_START) && (bias_cnt == BIAS_MAX) && !low_ok |=> (state == gdmf_pkg::GDMF_ACTIVE);
   endproperty
   a_bias_tmo: assert property (p_bias_tmo) else $error("bias start timeout missed");

   property p_low_enter;
      !out_enable && low_ok && (state == gdmf_pkg::GDMF_ACTIVE || state == gdmf_pkg::GDMF_BIAS_START)
         |=> (state == gdmf_pkg::GDMF_STANDBY || state == gdmf_pkg::GDMF_SLEEP);
   endproperty
   a_low_enter: assert property (p_low_enter) else $error("low power mode not entered");

   property p_amp_stay;
      (state == gdmf_pkg::GDMF_STANDBY) && !amp_standby_off |=> supply.amp_en;
   endproperty
   a_amp_stay: assert property (p_amp_stay) else $error("amplifiers off in standby");

   property p_ldo_on;
      (state != gdmf_pkg::GDMF_SLEEP) |=> supply.logic_ldo_en;
   endproperty
   a_ldo_on: assert property (p_ldo_on) else $error("logic regulator off outside sleep");

   property p_break_make;
      ((gate_out.hi & $past(gate_out.lo)) | (gate_out.lo & $past(gate_out.hi))) == 3'h0;
   endproperty
   a_break_make: assert property (p_break_make) else $error("gate switched side without off cycle");

   property p_wake_restart;
      (state == gdmf_pkg::GDMF_SLEEP) && wake_ok |=> (state == gdmf_pkg::GDMF_LDO_START);
   endproperty
   a_wake_restart: assert property (p_wake_restart) else $error("qualified wake did not restart");

endmodule : gdmf_ctrl

// >>> inc/gdmf_map.svh
// gdmf_map.svh: register offsets, field positions, reset values and times of the gate driver mode/fault block
// assumes: included by bare name, 32-bit apb data, one register per aligned word
`ifndef GDMF_MAP_SVH
`define GDMF_MAP_SVH

// register byte offsets
`define GDMF_CONFIG_REG_ZERO_OFS  8'h00
`define GDMF_DEAD_GAP_CONFIG_OFS  8'h04
`define GDMF_STATUS_OFS           8'h08
`define GDMF_INT_STAT_OFS         8'h0C
`define GDMF_INT_MASK_OFS         8'h10

// config_reg_zero fields
`define GDMF_CFG_AMP_OFF_BIT      0
`define GDMF_CFG_DEEP_IDLE_BIT    1
`define GDMF_CFG_RESET            2'h0

// dead_gap_config field
`define GDMF_GAP_W                8
`define GDMF_GAP_RESET            8'h00

// status fields
`define GDMF_ST_MODE_LSB          0
`define GDMF_ST_LATCH_LSB         8
`define GDMF_ST_COND_LSB          16

// interrupt events
`define GDMF_EV_W                 4
`define GDMF_EV_FAULT             0
`define GDMF_EV_LOW_POWER         1
`define GDMF_EV_ACTIVE            2
`define GDMF_EV_WAKE              3
`define GDMF_EV_RESET             4'h0

// times, in their own units
`define GDMF_CLK_NS               25
`define GDMF_GATE_OFF_NS          100
`define GDMF_OE_LOW_NS            1000000
`define GDMF_BIAS_TMO_NS          15000000
`define GDMF_RESUME_LOW_NS        1000

`endif

// >>> inc/gdmf_pkg.sv
// gdmf_pkg: types shared by the gate driver mode/fault block
// assumes: nothing outside itself
package gdmf_pkg;

   typedef enum logic [2:0]
   {
      GDMF_LDO_START,
      GDMF_BIAS_START,
      GDMF_ACTIVE,
      GDMF_STANDBY,
      GDMF_SLEEP
   } gdmf_mode_e;

   // bit p of hi is gate_<p>_upper / phase_<p>_hi_cmd, a=0 b=1 c=2
   typedef struct packed
   {
      logic [2:0] hi;
      logic [2:0] lo;
   } gdmf_gate_s;

   typedef struct packed
   {
      logic logic_ldo_en;
      logic gate_bias_en;
      logic pump_en;
      logic bias_from_pump;
      logic amp_en;
   } gdmf_supply_s;

endpackage : gdmf_pkg

// >>> verification/gdmf_host_model.sv
// gdmf_host_model: host side of the gate driver, drives output-enable, wake and phase commands
// assumes: same clock as the block, the bench calls its tasks, inputs change by nba after a rising edge
`timescale 1ns/10ps

module gdmf_host_model
#(
   parameter int OE_LOW = 20
)
(
   input  wire logic                 clk_sys,
   output      logic                 out_enable,
   output      logic                 wake_in,
   output      gdmf_pkg::gdmf_gate_s phase_cmd
);

   initial
   begin
      out_enable = 1'b0;
      wake_in    = 1'b0;
      phase_cmd  = '0;
   end

   task automatic oe_set(input logic v);
      @(posedge clk_sys);
      out_enable <= v;
   endtask : oe_set

   // fault clear pulse, kept short of the low qualification
   task automatic oe_pulse(input int n);
      if (n >= OE_LOW) n = OE_LOW - 1;
      oe_set(1'b0);
      repeat (n - 1) @(posedge clk_sys);
      oe_set(1'b1);
   endtask : oe_pulse

   // wake low for n cycles, then left high
   task automatic wake_pulse(input int n);
      @(posedge clk_sys);
      wake_in <= 1'b0;
      repeat (n) @(posedge clk_sys);
      wake_in <= 1'b1;
   endtask : wake_pulse

   // break before make: one all-off cycle, never both sides of a phase
   task automatic drive_phase(input gdmf_pkg::gdmf_gate_s cmd);
      @(posedge clk_sys);
      phase_cmd <= '0;
      @(posedge clk_sys);
      phase_cmd <= '{hi: cmd.hi, lo: cmd.lo & ~cmd.hi};
   endtask : drive_phase

endmodule : gdmf_host_model

// >>> verification/tb_top.sv
// tb_top: self-checking bench of the gate driver mode and fault block
// assumes: design parameters shortened, the host model drives the enable, wake and phase pins, apb on clk_sys
`timescale 1ns/10ps
`include "gdmf_map.svh"

module tb_top;
   localparam int OE_LOW   = 20;
   localparam int BIAS_TMO = 30;
   localparam int TMO_CYC  = 4000;

   logic                   clk_sys = 1'b0;
   logic                   rst_b;
   logic                   psel;
   logic                   penable;
   logic                   pwrite;
   logic [7:0]             paddr;
   logic [31:0]            pwdata;
   logic [31:0]            prdata;
   logic                   pready;
   logic                   pslverr;
   logic                   out_enable;
   logic                   wake_in;
   gdmf_pkg::gdmf_gate_s   phase_cmd;
   logic [3:0]             fault_cond;
   logic                   ldo_ready;
   logic                   gate_bias_ready;
   logic                   pump_request;
   gdmf_pkg::gdmf_gate_s   gate_out;
   gdmf_pkg::gdmf_supply_s supply;
   logic                   alarm_o;
   logic                   alarm_oe;
   logic                   irq;
   int                     n_errors = 0;
   int                     checks_done = 0;
   int                     cyc = 0;
   int                     b;
   logic [31:0]            rd;
   logic                   err;
   gdmf_pkg::gdmf_gate_s   cmd;

   gdmf_ctrl #(.NF(4), .OE_LOW_CYC(OE_LOW), .BIAS_TMO_CYC(BIAS_TMO), .RESUME_LOW_MIN_NS(100)) u_gdmf_ctrl
   (
      .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .out_enable(out_enable),
      .wake_in(wake_in), .phase_cmd(phase_cmd), .fault_cond(fault_cond), .ldo_ready(ldo_ready),
      .gate_bias_ready(gate_bias_ready), .pump_request(pump_request), .gate_out(gate_out), .supply(supply),
      .alarm_o(alarm_o), .alarm_oe(alarm_oe), .irq(irq)
   );

   gdmf_host_model #(.OE_LOW(OE_LOW)) u_gdmf_host_model
   (
      .clk_sys(clk_sys), .out_enable(out_enable), .wake_in(wake_in), .phase_cmd(phase_cmd)
   );

   always #12.5 clk_sys = ~clk_sys;

   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == TMO_CYC)
      begin
         n_errors++;
         end_of_test();
      end
   end

   function automatic gdmf_pkg::gdmf_gate_s exp_gate(input gdmf_pkg::gdmf_gate_s c, input logic run);
      return run ? {c.hi, c.lo & ~c.hi} : 6'h00;
   endfunction : exp_gate

   function automatic logic exp_amp(input logic amp_off, input logic oe);
      return oe | ~amp_off;
   endfunction : exp_amp

   task automatic end_of_test;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_of_test

   task automatic chk_bit(input logic got, input logic exp, input string what);
      checks_done++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask : chk_bit

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk_word

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tick

   // one apb transfer, held until pready is sampled high; only the bench timeout ends a wait
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk_sys);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      do
         @(posedge clk_sys);
      while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
      apb(1'b0, a, 32'h0);
      chk_word(rd & m, exp, "register read");
      chk_bit(err, 1'b0, "read error flag");
   endtask : rd_chk

   task automatic mode_chk(input gdmf_pkg::gdmf_mode_e m);
      rd_chk(`GDMF_STATUS_OFS, 32'(m), 32'h7);
   endtask : mode_chk

   initial
   begin
      rst_b           = 1'b0;
      psel            = 1'b0;
      penable         = 1'b0;
      pwrite          = 1'b0;
      paddr           = 8'h00;
      pwdata          = 32'h0000_0000;
      fault_cond      = 4'h0;
      ldo_ready       = 1'b0;
      gate_bias_ready = 1'b0;
      pump_request    = 1'b0;
      void'($urandom(32'h441BC6F8));
      repeat (4) @(posedge clk_sys);
      rst_b <= 1'b1;
      u_gdmf_host_model.oe_set(1'b1);
      tick(1);
      chk_bit(alarm_oe, 1'b1, "alarm during start-up");
      chk_bit(supply.logic_ldo_en, 1'b1, "ldo at start");
      for (b = 0; b < 5; b++) rd_chk(8'(4 * b), 32'h0, 32'hFFFFFFFF);
      apb(1'b0, 8'h14, 32'h0);
      chk_bit(err, 1'b1, "unmapped error");
      chk_word(rd, 32'h0, "unmapped data");
      apb(1'b1, `GDMF_DEAD_GAP_CONFIG_OFS, 32'hFFFFFFFF);
      rd_chk(`GDMF_DEAD_GAP_CONFIG_OFS, 32'h000000FF, 32'hFFFFFFFF);
      apb(1'b1, `GDMF_DEAD_GAP_CONFIG_OFS, 32'h0);
      apb(1'b1, `GDMF_INT_MASK_OFS, 32'h1);
      u_gdmf_host_model.wake_pulse(1);
      @(posedge clk_sys) ldo_ready <= 1'b1;
      tick(3);
      chk_bit(alarm_oe, 1'b0, "alarm after ldo ready");
      tick(BIAS_TMO + 6);
      mode_chk(gdmf_pkg::GDMF_ACTIVE);
      @(posedge clk_sys) pump_request <= 1'($urandom);
      tick(4);
      chk_word(32'(supply), {27'h0, 2'b11, pump_request, pump_request, 1'b1}, "supply active");
      repeat (8)
      begin
         cmd = 6'($urandom);
         u_gdmf_host_model.drive_phase(cmd);
         tick(3);
         chk_word({26'h0, gate_out}, {26'h0, exp_gate(cmd, 1'b1)}, "gate follow");
      end
      apb(1'b1, `GDMF_DEAD_GAP_CONFIG_OFS, 32'h6);
      u_gdmf_host_model.drive_phase(6'h07);
      tick(12);
      cmd = 6'h38;
      u_gdmf_host_model.drive_phase(cmd);
      tick(2);
      chk_word({29'h0, gate_out.hi}, 32'h0, "gap holds upper off");
      tick(8);
      chk_word({26'h0, gate_out}, {26'h0, exp_gate(cmd, 1'b1)}, "gate after gap");
      b = $urandom % 4;
      @(posedge clk_sys) fault_cond[b] <= 1'b1;
      tick(2);
      chk_bit(alarm_oe, 1'b1, "alarm on fault");
      chk_bit(alarm_o, 1'b0, "alarm pin data low");
      chk_bit(irq, 1'b1, "fault interrupt");
      rd_chk(`GDMF_STATUS_OFS, 32'h1 << (`GDMF_ST_LATCH_LSB + b), 32'h00000F00);
      u_gdmf_host_model.oe_set(1'b0);
      tick(3);
      chk_word({26'h0, gate_out}, {26'h0, exp_gate(cmd, 1'b0)}, "gates off on enable low");
      u_gdmf_host_model.oe_set(1'b1);
      tick(3);
      chk_bit(alarm_oe, 1'b1, "alarm kept, fault live");
      @(posedge clk_sys) fault_cond[b] <= 1'b0;
      tick(3);
      chk_bit(alarm_oe, 1'b1, "alarm kept until enable rise");
      rd_chk(`GDMF_INT_STAT_OFS, 32'h5, 32'h5);
      apb(1'b1, `GDMF_INT_STAT_OFS, 32'h1);
      tick(2);
      chk_bit(irq, 1'b0, "interrupt cleared");
      u_gdmf_host_model.oe_pulse(5);
      tick(3);
      chk_bit(alarm_oe, 1'b0, "alarm cleared");
      mode_chk(gdmf_pkg::GDMF_ACTIVE);
      apb(1'b1, `GDMF_CONFIG_REG_ZERO_OFS, 32'h1);
      u_gdmf_host_model.oe_set(1'b0);
      tick(OE_LOW - 8);
      mode_chk(gdmf_pkg::GDMF_ACTIVE);
      tick(10);
      mode_chk(gdmf_pkg::GDMF_STANDBY);
      chk_word(32'(supply), {27'h0, 1'b1, 3'b000, exp_amp(1'b1, 1'b0)}, "standby supply");
      chk_bit(irq, 1'b0, "masked low-power event");
      rd_chk(`GDMF_INT_STAT_OFS, 32'h2, 32'h2);
      u_gdmf_host_model.oe_set(1'b1);
      @(posedge clk_sys) gate_bias_ready <= 1'b1;
      tick(6);
      mode_chk(gdmf_pkg::GDMF_ACTIVE);
      apb(1'b1, `GDMF_CONFIG_REG_ZERO_OFS, 32'h2);
      u_gdmf_host_model.oe_set(1'b0);
      tick(OE_LOW + 6);
      mode_chk(gdmf_pkg::GDMF_SLEEP);
      chk_bit(supply.logic_ldo_en, 1'b0, "ldo off in sleep");
      @(posedge clk_sys) ldo_ready <= 1'b0;
      u_gdmf_host_model.wake_pulse(2);
      tick(3);
      mode_chk(gdmf_pkg::GDMF_SLEEP);
      u_gdmf_host_model.wake_pulse(10);
      tick(3);
      chk_bit(alarm_oe, 1'b1, "alarm after wake");
      chk_bit(supply.logic_ldo_en, 1'b1, "ldo after wake");
      mode_chk(gdmf_pkg::GDMF_LDO_START);
      rd_chk(`GDMF_INT_STAT_OFS, 32'h8, 32'h8);
      @(posedge clk_sys) ldo_ready <= 1'b1;
      tick(3);
      chk_bit(alarm_oe, 1'b0, "alarm released after wake");
      end_of_test();
   end

endmodule : tb_top
